// ===== src/congestion_flow_defs.vh
// Constants for the congestion flow table: offsets, fields, resets, timing.
// Assumes inclusion by bare name from design files of the flow table block.
`ifndef CONGESTION_FLOW_DEFS_VH
`define CONGESTION_FLOW_DEFS_VH

`define CF_TABLE_BASE        16'h0900
`define CF_TABLE_LAST        16'h093C
`define CF_ENTRIES           16
`define CF_DISCRETE          15
`define CF_CNT_W             3
`define CF_CATCH_CNT_W       5
`define CF_ID_W              16
`define CF_TT_LSB            16
`define CF_TT_MSB            17
`define CF_TT_RESET          2'h1
`define CF_TT_8BIT           2'h0
`define CF_ID_RESET          16'h0000
`define CF_MASK_RESET        16'hFFFF
`define CF_PKT_TYPE_CCP      4'h7
`define CF_TIMEOUT_W         4
`define CF_EXT_W             2
`define CF_EXT_REVS          2'h3
`define CF_TICK_NS           1000
`define CF_CLK_NS            10
`define CF_TICK_CYCLES       (`CF_TICK_NS / `CF_CLK_NS)

`endif

// ===== src/xoff_counter.v
// One flow table entry counter with its implicit-Xon timer.
// Assumes a single clock; events arrive as one-cycle pulses, qualified by ce.
`timescale 1ns/100ps
`include "congestion_flow_defs.vh"

module xoff_counter
#(
    parameter CNT_W = 3
)
(
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    // Events
    input  wire             xoff_hit,
    input  wire             xon_hit,
    input  wire             timecode_tick,
    input  wire [3:0]       timeout_limit,
    // State
    output reg  [CNT_W-1:0] count,
    output wire             blocked
);

    reg [`CF_TIMEOUT_W-1:0] timecode;
    reg [`CF_EXT_W-1:0]     revs;
    wire                    expire;
    wire                    full;

    assign blocked = (count != {CNT_W{1'b0}});
    assign full    = (count == {CNT_W{1'b1}});
    // Three full revolutions of the 4-bit time code give 3X the time-out
    assign expire  = blocked && timecode_tick && (timecode == timeout_limit) && (revs == `CF_EXT_REVS - 2'h1);

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count    <= {CNT_W{1'b0}};
            timecode <= {`CF_TIMEOUT_W{1'b0}};
            revs     <= {`CF_EXT_W{1'b0}};
        end
        else if (ce)
        begin
            if (xoff_hit)
            begin
                if (!full)
                    count <= count + {{(CNT_W-1){1'b0}}, 1'b1};   // see [R04]
                timecode <= {`CF_TIMEOUT_W{1'b0}};                 // see [R21]
                revs     <= {`CF_EXT_W{1'b0}};
            end
            else if (expire)
            begin
                count    <= {CNT_W{1'b0}};                         // see [R13] see [R21]
                timecode <= {`CF_TIMEOUT_W{1'b0}};
                revs     <= {`CF_EXT_W{1'b0}};
            end
            else
            begin
                if (xon_hit && blocked)
                    count <= count - {{(CNT_W-1){1'b0}}, 1'b1};   // see [R11]
                if (!blocked)
                begin
                    timecode <= {`CF_TIMEOUT_W{1'b0}};
                    revs     <= {`CF_EXT_W{1'b0}};
                end
                else if (timecode_tick)
                begin
                    if (timecode == timeout_limit)
                    begin
                        timecode <= {`CF_TIMEOUT_W{1'b0}};
                        revs     <= revs + 2'h1;                   // see [R12]
                    end
                    else
                        timecode <= timecode + 4'h1;
                end
            end
        end
    end

endmodule

// ===== src/flow_source_gate.v
// Gate for one transmit source: compares its mask with the Xoff vector.
// Assumes mask and xoff vector are on the same clock as the source request.
`timescale 1ns/100ps
`include "congestion_flow_defs.vh"

module flow_source_gate
(
    // Table state
    input  wire [`CF_ENTRIES-1:0] xoff_vec,
    input  wire [`CF_ENTRIES-1:0] mask,
    input  wire [`CF_ENTRIES-1:0] target_hit,
    // Result
    output wire                   controlled,
    output wire                   target_blocked
);

    // All-zero mask never flow-controls the source
    assign controlled     = |(xoff_vec & mask);                // see [R14] see [R19] see [R20]
    assign target_blocked = |(xoff_vec & mask & target_hit);   // see [R03] see [R10]

endmodule

// ===== src/congestion_flow_table.v
// Congestion flow table: sixteen-entry Xoff count table with source gating.
// Assumes congestion notices arrive decoded as one-cycle pulses on clk and
// that transmit sources present their destination ID on the same clock.
`timescale 1ns/100ps
`include "congestion_flow_defs.vh"

// Function
// [R01] Type 7 packets are Xoff or Xon notices
// [R02] No response sent; lost notices tolerated
// [R03] Xoff blocks load/store and queue traffic
// [R04] Count repeated Xoff; need equal Xon count
// [R05] Notices consumed, never forwarded to memory
// [R06] Match by destination ID, ignore priority
// [R07] Sixteen entries: fifteen flows plus catch-all
// [R08] Three-bit counter for entries zero..fourteen
// [R09] Five-bit counter for catch-all entry
// [R10] Non-zero count disables the flow
// [R11] Xon decrements, saturating at zero
// [R12] Two extra time-code bits for timer
// [R13] Implicit Xon after three time-outs
// [R14] Per-source flow checking via mask
// [R15] Queue may stall at blocked head
// [R16] Sixteen words at 0x0900 to 0x093C
// [R17] Reserved zero, size field, destination ID
// [R18] Zero last ID means all other flows
// [R19] Sixteen-bit mask, all ones default
// [R20] Controlled if any masked entry blocked
// [R21] Timer expiry clears count; Xoff restarts
module congestion_flow_table
#(
    parameter SOURCES  = 2,
    parameter TICK_DIV = `CF_TICK_CYCLES
)
(
    // Clock, reset, enable
    input  wire                      clk,
    input  wire                      rst_n,
    input  wire                      ce,
    // Received packet from the logical layer
    input  wire                      rx_valid,
    input  wire [3:0]                rx_ftype,
    input  wire                      rx_xon,
    input  wire [15:0]               rx_destid,
    input  wire                      rx_tt16,
    input  wire                      rx_forward_in,
    // Configuration bus
    input  wire                      cfg_sel,
    input  wire                      cfg_wr,
    input  wire [15:0]               cfg_addr,
    input  wire [31:0]               cfg_wdata,
    output reg  [31:0]               cfg_rdata,
    output reg                       cfg_ack,
    // Time-out limit and source masks
    input  wire [3:0]                timeout_limit,
    input  wire [SOURCES*16-1:0]     source_mask,
    // Transmit sources: requested destination, permission out
    input  wire [SOURCES*16-1:0]     src_destid,
    output reg  [SOURCES-1:0]        src_controlled,
    output reg  [SOURCES-1:0]        src_blocked,
    // Status
    output reg  [`CF_ENTRIES-1:0]    xoff_state,
    output reg                       rx_forward_out
);

    localparam N = `CF_ENTRIES;

    reg  [15:0]  flow_destination_id [0:N-1];
    reg  [1:0]   id_size             [0:N-1];
    reg  [15:0]  tick_cnt;
    reg          timecode_tick;

    wire         ccp_seen;
    wire [N-1:0] match_vec;
    wire [N-1:0] blk_vec;
    wire         discrete_hit;
    wire [3:0]   word_idx;
    wire         in_table;

    // A congestion notice carries no response and is not passed on
    assign ccp_seen = rx_valid && (rx_ftype == `CF_PKT_TYPE_CCP);   // see [R01] see [R02]

    ////////////////////////////////////////////////////////////////////////
    // Shared time code tick for all entry timers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt      <= 16'h0000;
            timecode_tick <= 1'b0;
        end
        else if (ce)
        begin
            if (tick_cnt == TICK_DIV[15:0] - 16'h0001)
            begin
                tick_cnt      <= 16'h0000;
                timecode_tick <= 1'b1;
            end
            else
            begin
                tick_cnt      <= tick_cnt + 16'h0001;
                timecode_tick <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry matching and counters
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : entry
            wire [15:0] key;
            wire        hit;
            // 8-bit IDs compare only the low byte; priority is never looked at
            assign key = (id_size[g] == `CF_TT_8BIT) ? {8'h00, rx_destid[7:0]} : rx_destid;
            if (g < N - 1)
            begin : discrete
                assign hit = (key == flow_destination_id[g]);   // see [R06]
                xoff_counter
                #(
                    .CNT_W(`CF_CNT_W)                             // see [R08]
                )
                u_cnt
                (
                    .clk          (clk),
                    .rst_n        (rst_n),
                    .ce           (ce),
                    .xoff_hit     (ccp_seen && !rx_xon && hit),
                    .xon_hit      (ccp_seen && rx_xon && hit),
                    .timecode_tick(timecode_tick),
                    .timeout_limit(timeout_limit),
                    .count        (),
                    .blocked      (blk_vec[g])
                );
            end
            else
            begin : catch_all
                // Zero ID covers every flow outside the discrete entries
                assign hit = (flow_destination_id[g] == `CF_ID_RESET) ? !discrete_hit
                                                                      : (key == flow_destination_id[g]); // see [R18]
                xoff_counter
                #(
                    .CNT_W(`CF_CATCH_CNT_W)                       // see [R09]
                )
                u_cnt
                (
                    .clk          (clk),
                    .rst_n        (rst_n),
                    .ce           (ce),
                    .xoff_hit     (ccp_seen && !rx_xon && hit),
                    .xon_hit      (ccp_seen && rx_xon && hit),
                    .timecode_tick(timecode_tick),
                    .timeout_limit(timeout_limit),
                    .count        (),
                    .blocked      (blk_vec[g])
                );
            end
            assign match_vec[g] = hit;
        end
    endgenerate

    assign discrete_hit = |match_vec[N-2:0];   // see [R07]

    ////////////////////////////////////////////////////////////////////////
    // Per-source gating against the Xoff vector
    genvar s;
    generate
        for (s = 0; s < SOURCES; s = s + 1)
        begin : source
            wire [N-1:0] thit;
            wire         ctl;
            wire         tblk;
            wire         disc;
            genvar       e;
            for (e = 0; e < N - 1; e = e + 1)
            begin : cmp
                assign thit[e] = (src_destid[s*16 +: 16] == flow_destination_id[e]);
            end
            assign disc      = |thit[N-2:0];
            assign thit[N-1] = (flow_destination_id[N-1] == `CF_ID_RESET) ? !disc
                             : (src_destid[s*16 +: 16] == flow_destination_id[N-1]);
            flow_source_gate u_gate
            (
                .xoff_vec      (blk_vec),
                .mask          (source_mask[s*16 +: 16]),
                .target_hit    (thit),
                .controlled    (ctl),
                .target_blocked(tblk)
            );
            // A queue stalls at its head while the head flow is off and its entry is set in the source mask
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    src_controlled[s] <= 1'b0;
                    src_blocked[s]    <= 1'b0;
                end
                else if (ce)
                begin
                    src_controlled[s] <= ctl;
                    src_blocked[s]    <= tblk;   // see [R03] see [R15]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    assign in_table = cfg_sel && (cfg_addr >= `CF_TABLE_BASE) && (cfg_addr <= `CF_TABLE_LAST)
                    && (cfg_addr[1:0] == 2'h0);   // see [R16]
    assign word_idx = cfg_addr[5:2];

    integer i;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < N; i = i + 1)
            begin
                flow_destination_id[i] <= `CF_ID_RESET;   // see [R17]
                id_size[i]             <= `CF_TT_RESET;
            end
            cfg_rdata      <= 32'h00000000;
            cfg_ack        <= 1'b0;
            xoff_state     <= {N{1'b0}};
            rx_forward_out <= 1'b0;
        end
        else if (ce)
        begin
            cfg_ack        <= cfg_sel;
            xoff_state     <= blk_vec;                      // see [R10]
            rx_forward_out <= rx_forward_in && !ccp_seen;   // see [R05]
            if (in_table && cfg_wr)
            begin
                flow_destination_id[word_idx] <= cfg_wdata[15:0];
                id_size[word_idx]             <= cfg_wdata[`CF_TT_MSB:`CF_TT_LSB];
            end
            if (in_table && !cfg_wr)
                cfg_rdata <= {14'h0000, id_size[word_idx], flow_destination_id[word_idx]};   // see [R17]
            else
                cfg_rdata <= 32'h00000000;
        end
    end

endmodule

// ===== bench/fabric_notice_model.sv
// Fabric model: sends one packet toward the flow table per call.
// Assumes the caller runs on clk; lines change at the falling edge.
`timescale 1ns/100ps
module fabric_notice_model
(
    // Clock
    input  logic        clk,
    // Packet toward the table
    output logic        rx_valid,
    output logic [3:0]  rx_ftype,
    output logic        rx_xon,
    output logic [15:0] rx_destid,
    output logic        rx_forward_in
);
    initial
    begin
        rx_valid = 1'b0;
        rx_ftype = 4'h0;
        rx_xon = 1'b0;
        rx_destid = 16'h0000;
        rx_forward_in = 1'b0;
    end

    // Fire and forget: no reply is awaited
    task automatic send(input logic x, input logic [15:0] id, input logic [3:0] ft, input logic f);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_ftype = ft;
        rx_xon = x;
        rx_destid = id;
        rx_forward_in = f;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_ftype = ~ft;
        rx_xon = ~x;
        rx_destid = ~id;
        rx_forward_in = ~f;
    endtask
endmodule

// ===== bench/cft_properties.sv
// Checker for the congestion flow table, bound to its top module.
// Assumes one clock domain, clk, with async reset rst_n.
`timescale 1ns/100ps
module cft_properties
#(
    parameter SOURCES  = 2,
    parameter TICK_DIV = 1
)
(
    // Clock and reset
    input logic                  clk,
    input logic                  rst_n,
    input logic                  ce,
    // Notices and configuration
    input logic                  rx_valid,
    input logic [3:0]            rx_ftype,
    input logic                  rx_xon,
    input logic                  rx_forward_out,
    input logic                  cfg_sel,
    input logic [31:0]           cfg_rdata,
    input logic                  cfg_ack,
    // Table and sources
    input logic [3:0]            timeout_limit,
    input logic [SOURCES*16-1:0] source_mask,
    input logic [SOURCES-1:0]    src_controlled,
    input logic [SOURCES-1:0]    src_blocked,
    input logic [15:0]           xoff_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [9:0] quiet;
    logic [9:0] bound;
    // Latest possible implicit Xon after the last Xoff
    assign bound = 10'(3 * (timeout_limit + 1) * TICK_DIV + TICK_DIV + 4);
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            quiet <= 10'h000;
        else if (ce && rx_valid && rx_ftype == 4'h7 && !rx_xon)
            quiet <= 10'h000;
        else if (quiet != 10'h3FF)
            quiet <= quiet + 10'h001;
    sequence s_notice;
        ce && rx_valid && rx_ftype == 4'h7;
    endsequence
    ////////////////////////////////////////
    a_ack_after_sel: assert property (ce && cfg_sel |=> cfg_ack)
        else $error("ack missing after access");
    a_rdata_idle_zero: assert property (!cfg_ack |-> cfg_rdata == 32'h0)
        else $error("read data without access");
    a_reserved_zero: assert property (cfg_rdata[31:18] == 14'h0)
        else $error("reserved bits set");
    a_notice_consumed: assert property (s_notice |=> !rx_forward_out)
        else $error("notice forwarded");
    a_rise_needs_xoff: assert property ((xoff_state & ~$past(xoff_state)) != 16'h0 |->
        $past(ce && rx_valid && rx_ftype == 4'h7 && !rx_xon, 2))
        else $error("flow blocked without Xoff");
    a_ctl_follows_mask: assert property ($past(ce) |->
        src_controlled[0] == |(xoff_state & $past(source_mask[15:0])))
        else $error("controlled flag wrong");
    a_blocked_in_ctl: assert property ((src_blocked & ~src_controlled) == '0)
        else $error("blocked but not controlled");
    a_mask_zero_free: assert property ($past(source_mask[SOURCES*16-1 -: 16]) == 16'h0 |->
        !src_controlled[SOURCES-1])
        else $error("unmasked source controlled");
    a_timer_clears: assert property (quiet > bound |-> xoff_state == 16'h0)
        else $error("implicit Xon missing");
endmodule

bind congestion_flow_table cft_properties #(.SOURCES (SOURCES), .TICK_DIV (TICK_DIV)) i_cft_properties (
    .clk (clk), .rst_n (rst_n), .ce (ce), .rx_valid (rx_valid), .rx_ftype (rx_ftype),
    .rx_xon (rx_xon), .rx_forward_out (rx_forward_out), .cfg_sel (cfg_sel),
    .cfg_rdata (cfg_rdata), .cfg_ack (cfg_ack), .timeout_limit (timeout_limit),
    .source_mask (source_mask), .src_controlled (src_controlled),
    .src_blocked (src_blocked), .xoff_state (xoff_state)
);

// ===== bench/test_congestion_flow_table.sv
// Self-checking bench for the congestion flow table.
// Assumes the checker file binds itself to the table.
`timescale 1ns/100ps
module test_congestion_flow_table;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        rx_valid, rx_xon, rx_forward_in;
    logic [3:0]  rx_ftype;
    logic [15:0] rx_destid;
    logic        cfg_sel = 1'b0;
    logic        cfg_wr = 1'b0;
    logic [15:0] cfg_addr = 16'h0000;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] cfg_rdata, d;
    logic        cfg_ack, fwd_out;
    logic [31:0] mask = 32'hFFFFFFFF;
    logic [31:0] dest = 32'h0;
    logic [1:0]  ctl, blk;
    logic [15:0] xst, other;
    logic [3:0]  tlim = 4'h3;
    logic [15:0] ids [16];
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          e;

    always #5 clk = ~clk;

    congestion_flow_table #(.SOURCES (2), .TICK_DIV (4)) i_congestion_flow_table (
        .clk (clk), .rst_n (rst_n), .ce (ce), .rx_valid (rx_valid), .rx_ftype (rx_ftype),
        .rx_xon (rx_xon), .rx_destid (rx_destid), .rx_tt16 (1'b0), .rx_forward_in (rx_forward_in),
        .cfg_sel (cfg_sel), .cfg_wr (cfg_wr), .cfg_addr (cfg_addr), .cfg_wdata (cfg_wdata),
        .cfg_rdata (cfg_rdata), .cfg_ack (cfg_ack), .timeout_limit (tlim), .source_mask (mask),
        .src_destid (dest), .src_controlled (ctl), .src_blocked (blk), .xoff_state (xst),
        .rx_forward_out (fwd_out)
    );
    fabric_notice_model i_fabric_notice_model (
        .clk (clk), .rx_valid (rx_valid), .rx_ftype (rx_ftype), .rx_xon (rx_xon),
        .rx_destid (rx_destid), .rx_forward_in (rx_forward_in)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] word_of(input logic [15:0] id);
        return {14'h0, 2'b01, id};
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cfg_rw(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        @(negedge clk);
        cfg_sel = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_wdata = wd;
        @(negedge clk);
        cfg_sel = 1'b0;
        d = cfg_rdata;
        chk("cfg_ack", cfg_ack, 32'h1);
    endtask

    task automatic nt(input logic x, input logic [15:0] id, input logic [3:0] ft, input logic f);
        i_fabric_notice_model.send(x, id, ft, f);
    endtask

    task automatic chk_out(input logic [15:0] x, input int k);
        @(negedge clk);
        chk("xoff_state", xst, x);
        chk("src_controlled", ctl, {|(x & mask[31:16]), |(x & mask[15:0])});
        chk("src_blocked", blk, {1'b0, x[k] & mask[k]});
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            summarize();
        end
    end

    initial
    begin
        d = $urandom(32'h3555);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (e = 0; e < 17; e++)
        begin
            cfg_rw(0, 16'h0900 + 16'(e * 4), 32'h0);
            chk("entry_reset", d, (e == 16) ? 32'h0 : word_of(16'h0));
        end
        other = {5'h1E, 11'($urandom)};
        for (e = 0; e < 16; e++)
        begin
            ids[e] = (e == 15) ? 16'h0 : {e[3:0], 1'b1, 11'($urandom)};
            cfg_rw(1, 16'h0900 + 16'(e * 4), {14'($urandom), 2'b01, ids[e]});
            cfg_rw(0, 16'h0900 + 16'(e * 4), 32'h0);
            chk("entry_rw", d, word_of(ids[e]));
        end
        mask = 32'h0000FFFF;
        for (e = 3; e < 16; e += 12)
        begin
            dest = {2{(e == 15) ? other : ids[3]}};
            repeat (9) nt(0, dest[15:0], 4'h7, 0);
            chk_out(16'h1 << e, e);
            repeat (7) nt(1, dest[15:0], 4'h7, 0);
            chk_out((e == 15) ? 16'h1 << e : 16'h0, e);
            repeat (3) nt(1, dest[15:0], 4'h7, 0);
            chk_out(16'h0, e);
        end
        dest = {2{ids[5]}};
        nt(0, ids[5], {1'b1, 3'($urandom)}, 1);
        chk("forward", fwd_out, 32'h1);
        chk_out(16'h0, 5);
        nt(0, ids[5], 4'h7, 1);
        chk("forward", fwd_out, 32'h0);
        chk_out(16'h0020, 5);
        nt(1, ids[5], 4'h7, 0);
        chk_out(16'h0, 5);
        repeat (20)
        begin
            e = $urandom_range(14);
            mask[15:0] = 16'($urandom);
            dest = {2{ids[e]}};
            nt(0, ids[e], 4'h7, 0);
            chk_out(16'h1 << e, e);
            nt(1, ids[e], 4'h7, 0);
            chk_out(16'h0, e);
        end
        mask = 32'h0000FFFF;
        // An Xon that arrives while ce is low is not taken
        dest = {2{ids[4]}};
        nt(0, ids[4], 4'h7, 0);
        chk_out(16'h0010, 4);
        ce = 1'b0;
        nt(1, ids[4], 4'h7, 0);
        ce = 1'b1;
        chk_out(16'h0010, 4);
        nt(1, ids[4], 4'h7, 0);
        chk_out(16'h0, 4);
        // A non-zero last entry ID matches only itself
        cfg_rw(1, 16'h093C, word_of(other));
        dest = {2{other}};
        nt(0, other ^ 16'h0001, 4'h7, 0);
        chk_out(16'h0, 15);
        nt(0, other, 4'h7, 0);
        chk_out(16'h8000, 15);
        nt(1, other, 4'h7, 0);
        chk_out(16'h0, 15);
        // Eight-bit ID entry compares only the low byte of a notice
        cfg_rw(1, 16'h0900, {16'h0000, 8'h00, ids[0][7:0]});
        cfg_rw(0, 16'h0900, 32'h0);
        chk("entry_tt8", d, {16'h0000, 8'h00, ids[0][7:0]});
        dest = {2{8'h00, ids[0][7:0]}};
        nt(0, {8'hA5, ids[0][7:0]}, 4'h7, 0);
        chk_out(16'h0001, 0);
        nt(1, {8'h5A, ids[0][7:0]}, 4'h7, 0);
        chk_out(16'h0, 0);
        dest = {2{ids[2]}};
        nt(0, ids[2], 4'h7, 0);
        repeat (30) @(negedge clk);
        chk_out(16'h0004, 2);
        nt(0, ids[2], 4'h7, 0);
        repeat (30) @(negedge clk);
        chk_out(16'h0004, 2);
        repeat (40) @(negedge clk);
        chk_out(16'h0, 2);
        // Shorter time-out limit shortens the implicit Xon
        tlim = 4'h1;
        nt(0, ids[2], 4'h7, 0);
        repeat (12) @(negedge clk);
        chk_out(16'h0004, 2);
        repeat (30) @(negedge clk);
        chk_out(16'h0, 2);
        summarize();
    end
endmodule
